// ==== rtl/ssp_sio_port.sv ====
// ssp_sio_port.sv - device side of a separate-i/o ddr sram port, burst of two
// assumes k, k_n, c, c_n arrive as levels synchronous to sys_clk and are
// oversampled; the controller keeps to the load and clocking contract
// Contract
// RQ1 - write words are taken on rising k and rising k_n during writes
// RQ2 - a low cycle load starts a cycle and latches address with direction
// RQ3 - every read or write moves exactly two words in one clock period
// RQ4 - with load low, direction high reads and direction low writes
// RQ5 - address is captured only on rising k during reads and writes
// RQ6 - one address bus is shared, reads and writes time-multiplexed
// RQ7 - storage is two equal arrays; address width depends on data width
// RQ8 - address is ignored when the matching port is not selected
// RQ9 - on the byte-wide variant two nibble selects mask low and high nibble
// RQ10 - nibble selects are sampled on the same edge as their data word
// RQ11 - byte selects per word choose stored bytes; unselected bytes unchanged
// RQ12 - read words are driven on rising c and rising c_n
// RQ13 - in single clock mode read words follow rising k and k_n instead
// RQ14 - read bus is released to high impedance when no read is active
// RQ15 - every access begins on a rising edge of k
// RQ16 - k_n together with k captures the synchronous inputs
// RQ17 - controller phases c and c_n to cancel board flight differences
// RQ18 - loop-off input low gives one-cycle first-generation read latency
// RQ19 - free-running returned strobes follow c, or k in single clock mode
// RQ20 - read data follows load by fixed latency, first word then second
// RQ21 - controller alternates read and write loads over the shared bus
// RQ22 - controller holds load high on edges with no transaction
`include "ssp_map.svh"
`default_nettype none

module ssp_sio_port #(
  parameter int DATA_W   = `SSP_DATA_W,
  parameter int ADDR_W   = `SSP_ADDR_W,
  parameter int STORE_AW = `SSP_STORE_AW
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    in_clk_k,
  input  wire logic                    in_clk_k_n,
  input  wire logic                    out_clk_c,
  input  wire logic                    out_clk_c_n,
  input  wire logic                    single_clock_mode,
  input  wire logic                    delay_loop_off_n,
  input  wire logic                    cycle_load_n,
  input  wire logic                    read_not_write,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [DATA_W-1:0]       write_data,
  input  wire logic [`SSP_MAX_SEL-1:0] byte_write_sel_n,
  input  wire logic [`SSP_NIB_SEL-1:0] nibble_write_sel_n,
  output logic      [DATA_W-1:0]       read_data,
  output logic                         read_data_oe,
  output logic                         returned_strobe,
  output logic                         returned_strobe_n
);

  // byte-wide variant uses nibble lanes, the others nine-bit lanes
  localparam bit NIB    = (DATA_W == `SSP_NIB_DATA_W);
  localparam int LANE_W = NIB ? `SSP_NIB_LANE : `SSP_BYTE_LANE;

  ////////////////////////////////////////////////////////////////////////////
  // lane selects to a per-bit write enable; used for both burst words
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [`SSP_MAX_SEL-1:0] bsel_n,
    input logic [`SSP_NIB_SEL-1:0] nsel_n
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (NIB) begin
        m[i] = ~nsel_n[(i / LANE_W) % `SSP_NIB_SEL]; // see RQ9
      end else begin
        m[i] = ~bsel_n[(i / LANE_W) % `SSP_MAX_SEL]; // see RQ11
      end
    end
    return m;
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////////
  // clock pin edge detection
  logic [3:0]          pin_q;
  ssp_pkg::ssp_edges_t edges;

  // previous level of k, k_n, c, c_n
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_q <= 4'h0;
    end else begin
      pin_q <= {in_clk_k, in_clk_k_n, out_clk_c, out_clk_c_n};
    end
  end

  assign edges.k_rise  = in_clk_k & ~pin_q[3];
  assign edges.kn_rise = in_clk_k_n & ~pin_q[2]; // see RQ16
  assign edges.c_rise  = out_clk_c & ~pin_q[1];
  assign edges.cn_rise = out_clk_c_n & ~pin_q[0];

  // loads are only recognised on rising k
  logic load_wr;
  logic load_rd;
  assign load_wr = edges.k_rise & ~cycle_load_n & ~read_not_write; // see RQ2 see RQ4 see RQ15
  assign load_rd = edges.k_rise & ~cycle_load_n & read_not_write;  // see RQ2 see RQ4 see RQ15

  ////////////////////////////////////////////////////////////////////////////
  // write port
  ssp_pkg::ssp_wr_state_t wr_state;
  logic [STORE_AW-1:0]    wr_addr;
  logic [DATA_W-1:0]      wr_d0;
  logic [DATA_W-1:0]      wr_m0;
  logic                   wr_accept;
  logic                   mem_we;
  logic [DATA_W-1:0]      now_mask;

  // a new write can overlap the rising k that commits the previous one
  assign wr_accept = load_wr && (wr_state != ssp_pkg::WR_D0);
  assign mem_we    = (wr_state == ssp_pkg::WR_D1) && edges.k_rise; // see RQ3
  assign now_mask  = lane_mask(byte_write_sel_n, nibble_write_sel_n); // see RQ10

  // write burst sequence: load on k, word 0 on k_n, word 1 on next k
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_state <= ssp_pkg::WR_IDLE;
    end else begin
      unique case (wr_state)
        ssp_pkg::WR_IDLE: begin
          if (wr_accept) begin
            wr_state <= ssp_pkg::WR_D0;
          end
        end
        ssp_pkg::WR_D0: begin
          if (edges.kn_rise) begin
            wr_state <= ssp_pkg::WR_D1; // see RQ1
          end
        end
        ssp_pkg::WR_D1: begin
          if (edges.k_rise) begin
            wr_state <= wr_accept ? ssp_pkg::WR_D0 : ssp_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end

  // write address held only from an accepted write load
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_addr <= '0;
    end else if (wr_accept) begin
      wr_addr <= addr[STORE_AW-1:0]; // see RQ5 see RQ6 see RQ8
    end
  end

  // first word and its mask, taken on rising k_n
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_d0 <= '0;
      wr_m0 <= '0;
    end else if ((wr_state == ssp_pkg::WR_D0) && edges.kn_rise) begin
      wr_d0 <= write_data; // see RQ1
      wr_m0 <= now_mask;   // see RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage; second word and its mask go straight in on the commit edge
  logic [DATA_W-1:0] mem_r0;
  logic [DATA_W-1:0] mem_r1;

  ssp_twin_bank #(
    .DATA_W   (DATA_W),
    .STORE_AW (STORE_AW)
  ) u_bank (
    .sys_clk (sys_clk),
    .we      (mem_we),
    .waddr   (wr_addr),
    .wdata0  (wr_d0),
    .wmask0  (wr_m0),
    .wdata1  (write_data),
    .wmask1  (now_mask),
    .raddr   (addr[STORE_AW-1:0]),
    .rdata0  (mem_r0),
    .rdata1  (mem_r1)
  ); // see RQ7

  ////////////////////////////////////////////////////////////////////////////
  // read port: launch edges depend on clock mode and loop setting
  logic dll_on;
  logic o_pos;
  logic o_neg;
  logic first_edge;
  logic second_edge;

  assign dll_on      = delay_loop_off_n;
  assign o_pos       = single_clock_mode ? edges.k_rise : edges.c_rise;   // see RQ12 see RQ13
  assign o_neg       = single_clock_mode ? edges.kn_rise : edges.cn_rise; // see RQ12 see RQ13
  // loop on: one rising c, then word 0 on c_n; loop off: word 0 on next c
  assign first_edge  = dll_on ? o_neg : o_pos; // see RQ18 see RQ20
  assign second_edge = dll_on ? o_pos : o_neg;

  logic              a_v;
  logic [DATA_W-1:0] a_w0;
  logic [DATA_W-1:0] a_w1;
  logic              b_v;
  logic [DATA_W-1:0] b_w0;
  logic [DATA_W-1:0] b_w1;
  logic              src_v;
  logic [DATA_W-1:0] src_w0;
  logic [DATA_W-1:0] src_w1;
  logic              launch;
  logic [DATA_W-1:0] out_w1;

  ssp_pkg::ssp_rd_state_t rd_state;

  assign src_v  = dll_on ? b_v : a_v;
  assign src_w0 = dll_on ? b_w0 : a_w0;
  assign src_w1 = dll_on ? b_w1 : a_w1;
  assign launch = first_edge && src_v && (rd_state != ssp_pkg::RD_W0);

  // stage a: words fetched at the read load; a new load wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      a_v <= 1'b0;
    end else if (load_rd) begin
      a_v <= 1'b1;
    end else if (dll_on ? o_pos : launch) begin
      a_v <= 1'b0;
    end
  end

  // stage a data, fetched only on a read load
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      a_w0 <= '0;
      a_w1 <= '0;
    end else if (load_rd) begin
      a_w0 <= mem_r0; // see RQ8
      a_w1 <= mem_r1;
    end
  end

  // stage b: the extra half cycle when the delay loop is running
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      b_v  <= 1'b0;
      b_w0 <= '0;
      b_w1 <= '0;
    end else if (dll_on && o_pos) begin
      b_v  <= a_v;
      b_w0 <= a_w0;
      b_w1 <= a_w1;
    end else if (launch) begin
      b_v  <= 1'b0;
    end
  end

  // read burst sequence on the output bus
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_state <= ssp_pkg::RD_IDLE;
    end else begin
      unique case (rd_state)
        ssp_pkg::RD_IDLE: begin
          if (launch) begin
            rd_state <= ssp_pkg::RD_W0;
          end
        end
        ssp_pkg::RD_W0: begin
          if (second_edge) begin
            rd_state <= ssp_pkg::RD_W1; // see RQ3
          end
        end
        ssp_pkg::RD_W1: begin
          if (first_edge) begin
            rd_state <= launch ? ssp_pkg::RD_W0 : ssp_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  // output words: first on the launch edge, second on the next one
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      read_data <= '0;
      out_w1    <= '0;
    end else if (launch) begin
      read_data <= src_w0; // see RQ12 see RQ20
      out_w1    <= src_w1;
    end else if ((rd_state == ssp_pkg::RD_W0) && second_edge) begin
      read_data <= out_w1; // see RQ20
    end
  end

  // bus released once the second word has had its half period
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      read_data_oe <= 1'b0;
    end else if (launch) begin
      read_data_oe <= 1'b1;
    end else if ((rd_state == ssp_pkg::RD_W1) && first_edge) begin
      read_data_oe <= 1'b0; // see RQ14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // returned strobes: copies of the launch clock, so data and strobe align
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      returned_strobe   <= 1'b0;
      returned_strobe_n <= 1'b0;
    end else begin
      returned_strobe   <= single_clock_mode ? in_clk_k : out_clk_c;     // see RQ19
      returned_strobe_n <= single_clock_mode ? in_clk_k_n : out_clk_c_n; // see RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  wr_addr_latch_a : assert property ( // see RQ5
    @(posedge sys_clk) disable iff (!rstn)
    wr_accept |=> wr_addr == $past(addr[STORE_AW-1:0])
  ) else $error("write address not latched on load");

  addr_ignored_a : assert property ( // see RQ8
    @(posedge sys_clk) disable iff (!rstn)
    !wr_accept |=> $stable(wr_addr)
  ) else $error("write address changed without a write load");

  commit_on_k_a : assert property ( // see RQ15
    @(posedge sys_clk) disable iff (!rstn)
    mem_we |-> edges.k_rise && $past(wr_state == ssp_pkg::WR_D1)
  ) else $error("write commit off a rising k");

  word0_capture_a : assert property ( // see RQ1
    @(posedge sys_clk) disable iff (!rstn)
    (wr_state == ssp_pkg::WR_D0) && edges.kn_rise
      |=> (wr_state == ssp_pkg::WR_D1) && (wr_d0 == $past(write_data))
  ) else $error("first write word not taken on rising k_n");

  mask_per_word_a : assert property ( // see RQ10
    @(posedge sys_clk) disable iff (!rstn)
    (wr_state == ssp_pkg::WR_D0) && edges.kn_rise
      |=> wr_m0 == lane_mask($past(byte_write_sel_n), $past(nibble_write_sel_n))
  ) else $error("first word mask not sampled with its data");

  bus_release_a : assert property ( // see RQ14
    @(posedge sys_clk) disable iff (!rstn)
    (rd_state == ssp_pkg::RD_IDLE) && !$past(launch) |-> !read_data_oe
  ) else $error("read bus driven with no read active");

  launch_word0_a : assert property ( // see RQ12
    @(posedge sys_clk) disable iff (!rstn)
    launch |=> read_data_oe && (read_data == $past(src_w0))
  ) else $error("first read word not driven on launch edge");

  second_word_a : assert property ( // see RQ3
    @(posedge sys_clk) disable iff (!rstn)
    (rd_state == ssp_pkg::RD_W0) && second_edge && !launch
      |=> read_data_oe && (read_data == $past(out_w1))
  ) else $error("second read word missing");

  dll_off_latency_a : assert property ( // see RQ18
    @(posedge sys_clk) disable iff (!rstn)
    (!dll_on && !single_clock_mode && load_rd ##1 edges.c_rise) or
      (!dll_on && single_clock_mode && load_rd ##1 !edges.k_rise [*3] ##1 edges.k_rise) |-> launch
  ) else $error("loop-off read did not launch on next output edge");

  strobe_follow_a : assert property ( // see RQ19
    @(posedge sys_clk) disable iff (!rstn)
    ##1 returned_strobe == $past(single_clock_mode ? in_clk_k : out_clk_c)
  ) else $error("returned strobe does not follow launch clock");

endmodule : ssp_sio_port

`default_nettype wire

// ==== shared/ssp_map.svh ====
// ssp_map.svh - named figures for the separate-i/o burst-of-two sram port
// assumes inclusion by bare name from the design files and the testbench files
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// widths of the widest variant; narrower variants override the parameters
`define SSP_DATA_W      36
`define SSP_ADDR_W      20
`define SSP_ADDR_W_X18  21
`define SSP_ADDR_W_X8   22
// flip-flop storage address width, far smaller than the real array
`define SSP_STORE_AW    6

// write select shapes
`define SSP_MAX_SEL     4
`define SSP_NIB_SEL     2
`define SSP_NIB_LANE    4
`define SSP_BYTE_LANE   9
`define SSP_NIB_DATA_W  8

// clocking figures
`define SSP_SYS_CLK_MHZ  200
`define SSP_DELAY_LOOP_OFF_N_MAX_MHZ 167

`endif

// ==== shared/ssp_pkg.sv ====
// ssp_pkg.sv - types used by the sram port for edges and burst states
// assumes ssp_map.svh is on the include path
`default_nettype none

package ssp_pkg;

  // one-cycle pulses found on the sampled clock pins
  typedef struct packed {
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
  } ssp_edges_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_D0,
    WR_D1
  } ssp_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_W0,
    RD_W1
  } ssp_rd_state_t;

endpackage : ssp_pkg

`default_nettype wire

// ==== rtl/ssp_twin_bank.sv ====
// ssp_twin_bank.sv - two equal flip-flop arrays, one per burst word
// assumes one clock, masks active high per data bit, no reset of contents
`include "ssp_map.svh"
`default_nettype none

module ssp_twin_bank #(
  parameter int DATA_W   = `SSP_DATA_W,
  parameter int STORE_AW = `SSP_STORE_AW
) (
  input  wire logic                sys_clk,
  input  wire logic                we,
  input  wire logic [STORE_AW-1:0] waddr,
  input  wire logic [DATA_W-1:0]   wdata0,
  input  wire logic [DATA_W-1:0]   wmask0,
  input  wire logic [DATA_W-1:0]   wdata1,
  input  wire logic [DATA_W-1:0]   wmask1,
  input  wire logic [STORE_AW-1:0] raddr,
  output logic      [DATA_W-1:0]   rdata0,
  output logic      [DATA_W-1:0]   rdata1
);

  localparam int DEPTH = 1 << STORE_AW;

  logic [DATA_W-1:0] bank0 [DEPTH];
  logic [DATA_W-1:0] bank1 [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // masked commit: unselected bits keep their old value
  always_ff @(posedge sys_clk) begin
    if (we) begin
      bank0[waddr] <= (bank0[waddr] & ~wmask0) | (wdata0 & wmask0);
      bank1[waddr] <= (bank1[waddr] & ~wmask1) | (wdata1 & wmask1);
    end
  end

  // read is combinational; the port registers it at load time
  assign rdata0 = bank0[raddr];
  assign rdata1 = bank1[raddr];

endmodule : ssp_twin_bank

`default_nettype wire

// ==== testbench/ssp_ctl_model.sv ====
// ssp_ctl_model.sv - behavioural memory controller facing the sram port
// assumes the bench calls issue() from one process and keeps sys_clk running
`include "ssp_map.svh"
`default_nettype none

module ssp_ctl_model (
  input  wire logic                    sys_clk,
  input  wire logic                    single_clock_mode,
  output logic                         k,
  output logic                         k_n,
  output logic                         c,
  output logic                         c_n,
  output logic                         cycle_load_n,
  output logic                         read_not_write,
  output logic [`SSP_ADDR_W-1:0]       addr,
  output logic [`SSP_DATA_W-1:0]       write_data,
  output logic [`SSP_MAX_SEL-1:0]      byte_write_sel_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0]              ph;
  logic                    wr_cur;
  logic                    d1_pend;
  logic [`SSP_DATA_W-1:0]  cur_d0;
  logic [`SSP_DATA_W-1:0]  cur_d1;
  logic [`SSP_MAX_SEL-1:0] cur_s0;
  logic [`SSP_MAX_SEL-1:0] cur_s1;

  initial begin
    {ph, wr_cur, d1_pend, k, c} = '0;
    {k_n, c_n, cycle_load_n} = 3'h7;
    {read_not_write, addr, write_data, cur_d0, cur_d1} = '0;
    {byte_write_sel_n, cur_s0, cur_s1} = '1;
  end

  ////////////////////////////////////////////////////////////////////////
  // clock pins, two sys_clk per level; c lags k by one cycle
  always @(negedge sys_clk) begin
    ph <= ph + 2'h1;
    k <= (ph == 2'h3) || (ph == 2'h0);
    k_n <= (ph == 2'h1) || (ph == 2'h2);
    c <= ~single_clock_mode & ((ph == 2'h0) || (ph == 2'h1));
    c_n <= ~single_clock_mode & ((ph == 2'h2) || (ph == 2'h3)); // stands still in single mode
  end

  // write words on k_n and k rises, junk otherwise so stale data cannot pass
  always @(negedge sys_clk) begin
    if (ph == 2'h1) begin
      write_data <= wr_cur ? cur_d0 : ~write_data;
      byte_write_sel_n <= wr_cur ? cur_s0 : ~byte_write_sel_n;
      d1_pend <= wr_cur;
      wr_cur <= 1'b0;
    end else if (ph == 2'h3) begin
      write_data <= d1_pend ? cur_d1 : ~write_data;
      byte_write_sel_n <= d1_pend ? cur_s1 : ~byte_write_sel_n;
    end else begin
      write_data <= ~write_data;
      byte_write_sel_n <= ~byte_write_sel_n;
    end
    if (ph == 2'h1 || ph == 2'h2) begin
      addr <= ~addr;
      read_not_write <= ~read_not_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one load on the next k rise; back to back calls land on successive k rises
  task automatic issue(
    input logic                    rd,
    input logic [`SSP_ADDR_W-1:0]  a,
    input logic [`SSP_DATA_W-1:0]  d0,
    input logic [`SSP_DATA_W-1:0]  d1,
    input logic [`SSP_MAX_SEL-1:0] s0,
    input logic [`SSP_MAX_SEL-1:0] s1
  );
    @(negedge sys_clk);
    repeat (4) if (ph != 2'h3) @(negedge sys_clk);
    cycle_load_n <= 1'b0;
    read_not_write <= rd;
    addr <= a;
    wr_cur <= ~rd;
    cur_d0 <= d0;
    cur_d1 <= d1;
    cur_s0 <= s0;
    cur_s1 <= s1;
    @(negedge sys_clk);
    cycle_load_n <= 1'b1;
    read_not_write <= ~rd;
    addr <= ~a;
  endtask : issue
endmodule : ssp_ctl_model

`default_nettype wire

// ==== testbench/sio_burst2_sram_port_test.sv ====
// sio_burst2_sram_port_test.sv - self-checking bench for the sram port
// assumes the 36-bit variant with 64 stored locations and the model controller
`include "ssp_map.svh"
`default_nettype none

module sio_burst2_sram_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rstn, single_clock_mode, delay_loop_off_n;
  logic        k, k_n, c, c_n, cycle_load_n, read_not_write;
  logic [19:0] addr;
  logic [35:0] write_data, read_data;
  logic [3:0]  byte_write_sel_n;
  logic [1:0]  nibble_write_sel_n;
  logic        read_data_oe, returned_strobe, returned_strobe_n;
  logic        exp_rs, exp_rsn, chk_en, pend_v;
  logic [31:0] seed, r1, r2, r3;
  logic [35:0] mem0 [64];
  logic [35:0] mem1 [64];
  logic [35:0] exp_d [int];
  logic [35:0] pd0, pd1;
  logic [3:0]  ps0, ps1;
  logic [5:0]  pidx;
  int          cyc, pend_t0, miscompares, n_tests;

  ssp_sio_port #(.DATA_W(36), .ADDR_W(20), .STORE_AW(6)) u_ssp_sio_port (
    .sys_clk(sys_clk), .rstn(rstn), .in_clk_k(k), .in_clk_k_n(k_n),
    .out_clk_c(c), .out_clk_c_n(c_n), .single_clock_mode(single_clock_mode),
    .delay_loop_off_n(delay_loop_off_n), .cycle_load_n(cycle_load_n),
    .read_not_write(read_not_write), .addr(addr), .write_data(write_data),
    .byte_write_sel_n(byte_write_sel_n), .nibble_write_sel_n(nibble_write_sel_n),
    .read_data(read_data), .read_data_oe(read_data_oe),
    .returned_strobe(returned_strobe), .returned_strobe_n(returned_strobe_n));

  ssp_ctl_model u_ssp_ctl_model (
    .sys_clk(sys_clk), .single_clock_mode(single_clock_mode), .k(k), .k_n(k_n),
    .c(c), .c_n(c_n), .cycle_load_n(cycle_load_n), .read_not_write(read_not_write),
    .addr(addr), .write_data(write_data), .byte_write_sel_n(byte_write_sel_n));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // low select writes the 9-bit lane, the rest keeps the old value
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] sel_n);
    logic [35:0] res;
    res = o;
    for (int i = 0; i < 4; i++) if (!sel_n[i]) res[9*i +: 9] = n[9*i +: 9];
    return res;
  endfunction : merge

  // cycles from load to first read word, seen at the falling edge; c lags k by one
  function automatic int lat(input logic single, input logic loop_on);
    return (single ? 4 : 1) + (loop_on ? 2 : 0);
  endfunction : lat

  task automatic draw(output logic [31:0] r);
    seed = lfsr_next(seed);
    r = seed;
  endtask : draw

  task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic apply_pend;
    mem0[pidx] = merge(mem0[pidx], pd0, ps0);
    mem1[pidx] = merge(mem1[pidx], pd1, ps1);
    pend_v = 1'b0;
  endtask : apply_pend

  // one load; a read on the commit k rise of a write still sees old data
  task automatic do_op(input logic rd, input logic [19:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
    int t0;
    int l;
    u_ssp_ctl_model.issue(rd, a, d0, d1, s0, s1);
    t0 = cyc;
    l = lat(single_clock_mode, delay_loop_off_n);
    if (pend_v && t0 != pend_t0 + 4) apply_pend();
    if (rd) begin
      exp_d[t0 + l] = mem0[a[5:0]];
      exp_d[t0 + l + 1] = mem0[a[5:0]];
      exp_d[t0 + l + 2] = mem1[a[5:0]];
      exp_d[t0 + l + 3] = mem1[a[5:0]];
    end
    if (pend_v) apply_pend();
    if (!rd) begin
      {pend_v, pend_t0, pidx, pd0, pd1, ps0, ps1} = {1'b1, t0, a[5:0], d0, d1, s0, s1};
    end
  endtask : do_op

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // cycle counter and the strobe each pin should produce one cycle later
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    exp_rs <= single_clock_mode ? k : c;
    exp_rsn <= single_clock_mode ? k_n : c_n;
  end

  // read bus and strobes checked every cycle, settled at the falling edge
  always @(negedge sys_clk) begin
    if (chk_en) begin
      cmp_bit(read_data_oe, exp_d.exists(cyc) != 0, "oe");
      if (exp_d.exists(cyc)) cmp_data(read_data, exp_d[cyc]);
      cmp_bit(returned_strobe, exp_rs, "strobe");
      cmp_bit(returned_strobe_n, exp_rsn, "strobe_n");
    end
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    $display("MISMATCH t=%0t run did not finish", $time);
    stop_test();
  end

  initial begin
    {rstn, single_clock_mode, chk_en, pend_v, cyc, miscompares, n_tests} = '0;
    delay_loop_off_n = 1'b0;
    nibble_write_sel_n = 2'h3; // unused on the 36-bit variant
    seed = 32'h8ba2f80f;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    cmp_data(read_data, 36'h0);
    chk_en = 1'b1;
    // fill every location back to back so no lane is left unknown
    for (int i = 0; i < 64; i++) begin
      draw(r1);
      draw(r2);
      do_op(1'b0, 20'(i), {r1[3:0], r2}, {r1[7:4], r1 ^ r2}, 4'h0, 4'h0);
    end
    // all four clocking modes, random loads with gaps and aliased addresses
    for (int m = 0; m < 4; m++) begin
      repeat (16) @(negedge sys_clk);
      single_clock_mode = m[0];
      delay_loop_off_n = m[1];
      for (int n = 0; n < 60; n++) begin
        draw(r1);
        draw(r2);
        draw(r3);
        nibble_write_sel_n = r3[9:8]; // ignored off the byte-wide variant
        do_op(r1[16], {r1[31:20], r3[7:0]}, {r1[3:0], r2}, {r1[7:4], r3},
              r1[11:8], r1[15:12]);
        if (r1[17]) repeat (3) @(negedge sys_clk);
      end
      // write then read on its commit edge sees old data, the next read new
      do_op(1'b0, 20'h80005, 36'h0123456789, 36'hfedcba987, 4'h5, 4'ha);
      do_op(1'b1, 20'h00005, '0, '0, 4'hf, 4'hf);
      do_op(1'b1, 20'h40005, '0, '0, 4'hf, 4'hf);
    end
    repeat (16) @(negedge sys_clk);
    stop_test();
  end
endmodule : sio_burst2_sram_port_test

`default_nettype wire
